// ==== sfs_cap_model.sv ====
`timescale 1ns/100ps

// ------------------------------------------------------------
// delay capacitor with its threshold comparators
// ------------------------------------------------------------
module sfs_cap_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // current source controls from the block
  input wire sfs_pkg::sfs_cap_drive_s cap_drive,
  // test controls: half-rate ramps, pin shorted low or high
  input wire logic slow,
  input wire logic stuck_lo,
  input wire logic stuck_hi,
  // comparator events
  output logic cap_upper,
  output logic cap_lower,
  output logic cap_mid,
  output logic cap_fault_thresh
);
  // levels in tens of millivolts; the upper threshold is a plain pick
  localparam logic [7:0] TOP = 8'h80;
  localparam logic [7:0] MID = 8'h20;
  localparam logic [7:0] HOLD = 8'h73;
  localparam logic [7:0] FTH = 8'hf0;
  logic [7:0] lvl;
  logic [7:0] lvl_q;
  logic tgl;

  // cap voltage; with no source active it bleeds to ground at once
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl <= 8'h00;
      lvl_q <= 8'h00;
      tgl <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl;
      tgl <= ~tgl;
      if (stuck_lo)
        lvl <= 8'h00;
      else if (stuck_hi)
        lvl <= TOP;
      else if (slow && tgl)
        lvl <= lvl;
      else if (cap_drive.hold)
        lvl <= HOLD;
      // the fault ramp also raises charge, so it must win or it stops at the peak level
      else if (cap_drive.fault_ramp)
        lvl <= (lvl < FTH) ? lvl + 8'h01 : lvl;
      else if (cap_drive.charge)
        lvl <= (lvl < TOP) ? lvl + (cap_drive.fast ? 8'h04 : 8'h01) : lvl;
      else if (cap_drive.discharge)
        lvl <= (lvl != 8'h00) ? lvl - 8'h01 : lvl;
      else
        lvl <= 8'h00;
    end
  end

  // upper, lower and mid are one-cycle events per crossing, so each peak counts once; the fault threshold is a level
  assign cap_upper = (lvl == TOP) && (lvl_q != TOP);
  assign cap_lower = (lvl == 8'h00) && (lvl_q != 8'h00);
  assign cap_mid = (lvl >= MID) && (lvl_q < MID);
  assign cap_fault_thresh = (lvl >= FTH);
endmodule : sfs_cap_model

// ==== sfs_pkg.sv ====
package sfs_pkg;

  // ----------------------------------------------------------------
  // analog figures kept for reference (mV, %, degC, nF)
  // ----------------------------------------------------------------
  localparam int VDD_MIN_MV = 2500;
  localparam int HOLD_MV = 1150;
  localparam int FAULT_THRESH_MV = 2400;
  localparam int PIN_FAULT_MV = 600;
  localparam int REF_TOL_PCT = 20;
  localparam int TEMP_TRIP_C = 140;
  localparam int CAP_NF = 220;

  // ----------------------------------------------------------------
  // timing, scaled to a 220 nF delay capacitor
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int SS_TIME_US = 2000;
  localparam int FAULT_TIMEOUT_US = 50000;
  localparam int SS_CYCLES = SS_TIME_US * CLK_MHZ;
  localparam int FAULT_CYCLES = FAULT_TIMEOUT_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // sequence steps, counted in peaks
  // ----------------------------------------------------------------
  localparam logic [2:0] PK_NONE = 3'h0;
  localparam logic [2:0] PK_PROTECT = 3'h2;
  localparam logic [2:0] PK_SOFTSTART = 3'h2;
  localparam logic [2:0] PK_GATE_OFF = 3'h4;
  localparam logic [2:0] PK_DELAYED_BOOST_GATE_OUT = 3'h5;
  localparam logic [2:0] PK_GATE_ON = 3'h5;
  localparam logic [2:0] PK_LAST = 3'h6;

  // rail index in the packed rail vector
  localparam int RAIL_BOOST = 0;
  localparam int RAIL_LOGIC = 1;
  localparam int RAIL_GATE_OFF = 2;
  localparam int RAIL_GATE_ON = 3;
  localparam int NUM_RAILS = 4;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_UP,
    ST_DOWN,
    ST_RUN,
    ST_FRAMP,
    ST_LATCH
  } sfs_state_e;

  // delay capacitor current source controls
  typedef struct packed {
    logic charge;
    logic fast;
    logic discharge;
    logic hold;
    logic fault_ramp;
  } sfs_cap_drive_s;

  // rail enables, boost in bit 0
  typedef struct packed {
    logic gate_on;
    logic gate_off;
    logic logic_rail;
    logic boost;
  } sfs_rail_en_s;

  // output-fault comparators, high while faulted
  typedef struct packed {
    logic gate_on;
    logic logic_rail;
    logic gate_off;
    logic boost;
    logic protect_gate;
    logic delayed_gate;
  } sfs_out_fault_s;

endpackage : sfs_pkg

// ==== sfs_sequencer.sv ====
`timescale 1ns/100ps

// Operation
// - after any fault stay latched off until enable or supply cycles
// - enable low keeps the whole device powered down
// - enable high and supply good start the cap charge, fast then slow
// - with enable low the cap ramp waits for enable
// - a good start-up shows exactly six cap peaks
// - first ramp checks the cap only; a fault shuts everything off
// - second ramp checks reference and temperature; its peak enables protection
// - any fault turns the input protection transistor off; here an output fault does so only once its ramp latches
// - boost and logic soft-start begin with the third ramp, about 2 ms
// - gate-off regulator enabled at the fourth peak
// - delayed-boost gate pulled low at the fifth peak
// - gate-on enabled at sixth ramp start; all outputs checked at its end
// - reference and temperature must be good before soft-start, else latch
// - cap stuck low never starts; stuck high never completes
// - after start-up monitor everything and hold the cap at 1.15 V
// - cap, reference or temperature fault shuts down at once
// - other output faults ramp the cap at 5 uA to 2.4 V, then latch
// - a fault clearing before the threshold returns the cap to hold
// - protection and delayed-boost gates fault at about 0.6 V
// - integrator node forced high selects proportional-only boost
// - an output driven above target stops its drive until it recovers
// - die temperature past 140 C shuts the device down
// - output fault timeout is about 50 ms for 220 nF
module sfs_sequencer #(
  parameter int SS_CYCLES = sfs_pkg::SS_CYCLES,
  parameter int FAULT_CYCLES = sfs_pkg::FAULT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // device control
  input wire logic enable,
  input wire logic vdd_ok,
  // delay capacitor comparators
  input wire logic cap_upper,
  input wire logic cap_lower,
  input wire logic cap_mid,
  input wire logic cap_fault_thresh,
  input wire logic cap_fault,
  // supervisors
  input wire logic ref_bad,
  input wire logic over_temp,
  input wire sfs_pkg::sfs_out_fault_s out_fault,
  input wire logic [sfs_pkg::NUM_RAILS-1:0] over_volt,
  input wire logic integrator_cap_high,
  // delay capacitor drive
  output sfs_pkg::sfs_cap_drive_s cap_drive,
  // rail and gate control
  output sfs_pkg::sfs_rail_en_s rail_en,
  output logic [sfs_pkg::NUM_RAILS-1:0] drive_inhibit,
  output logic softstart_active,
  output logic p_mode,
  output logic input_protect_gate_out,
  output logic delayed_boost_gate_out,
  output logic delayed_boost_gate_oe,
  // status
  output logic seq_done,
  output logic latched_off,
  output logic powered_down
);

  sfs_pkg::sfs_state_e state;
  logic [2:0] peak_cnt;
  logic mid_seen;
  logic peak_ev;
  logic trough_ev;
  logic shut_now;
  logic any_out_fault;
  logic ss_done;
  logic fault_timeout;
  logic [sfs_pkg::NUM_RAILS-1:0] rail_bits;

  // ----------------------------------------------------------------
  // events and fault terms
  // ----------------------------------------------------------------
  // comparator pulses only count in the ramp direction that expects them
  assign peak_ev = (state == sfs_pkg::ST_UP) && cap_upper;
  assign trough_ev = (state == sfs_pkg::ST_DOWN) && cap_lower;
  // reference and temperature are not judged on the first ramp while they settle
  assign shut_now = cap_fault ||
    ((ref_bad || over_temp) && !((state == sfs_pkg::ST_UP) && (peak_cnt == sfs_pkg::PK_NONE)));
  // gate pins count as outputs, each fed by its 0.6 V comparator
  assign any_out_fault = |out_fault;
  assign rail_bits = rail_en;

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  // enable or supply loss wins over everything and is the only way out of latch
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= sfs_pkg::ST_OFF;
    else if (!enable || !vdd_ok)
      state <= sfs_pkg::ST_OFF;
    else
    begin
      unique case (state)
        sfs_pkg::ST_OFF:
          state <= sfs_pkg::ST_UP;
        sfs_pkg::ST_UP:
          if (shut_now)
            state <= sfs_pkg::ST_LATCH;
          else if (peak_ev && (peak_cnt == sfs_pkg::PK_LAST - 3'h1))
            state <= any_out_fault ? sfs_pkg::ST_LATCH : sfs_pkg::ST_RUN;
          else if (peak_ev)
            state <= sfs_pkg::ST_DOWN; // a cap held high gets here once at most, then sees no trough
        sfs_pkg::ST_DOWN:
          if (shut_now)
            state <= sfs_pkg::ST_LATCH;
          else if (trough_ev)
            state <= sfs_pkg::ST_UP;
        sfs_pkg::ST_RUN:
          if (shut_now)
            state <= sfs_pkg::ST_LATCH;
          else if (any_out_fault)
            state <= sfs_pkg::ST_FRAMP;
        sfs_pkg::ST_FRAMP:
          if (shut_now || cap_fault_thresh || fault_timeout)
            state <= sfs_pkg::ST_LATCH;
          else if (!any_out_fault)
            state <= sfs_pkg::ST_RUN;
        sfs_pkg::ST_LATCH:
          state <= sfs_pkg::ST_LATCH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // step counter
  // ----------------------------------------------------------------
  // one step per peak; troughs are told apart by the ramp direction
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      peak_cnt <= sfs_pkg::PK_NONE;
    else if (state == sfs_pkg::ST_OFF)
      peak_cnt <= sfs_pkg::PK_NONE;
    else if (peak_ev && !shut_now)
      peak_cnt <= peak_cnt + 3'h1;
  end

  // first ramp runs fast until the midway comparator fires
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mid_seen <= 1'b0;
    else if (state == sfs_pkg::ST_OFF)
      mid_seen <= 1'b0;
    else if (cap_mid)
      mid_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // delay capacitor drive
  // ----------------------------------------------------------------
  // decoded one cycle behind the state, so the source never glitches on a change
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cap_drive <= '0;
    else
    begin
      cap_drive.charge <= (state == sfs_pkg::ST_UP) || (state == sfs_pkg::ST_FRAMP);
      cap_drive.fast <= (state == sfs_pkg::ST_UP) && (peak_cnt == sfs_pkg::PK_NONE)
        && !mid_seen;
      cap_drive.discharge <= (state == sfs_pkg::ST_DOWN);
      cap_drive.hold <= (state == sfs_pkg::ST_RUN);
      cap_drive.fault_ramp <= (state == sfs_pkg::ST_FRAMP);
    end
  end

  // ----------------------------------------------------------------
  // rail enables
  // ----------------------------------------------------------------
  // cleared the same edge a shutdown fault is seen, not one later; after a fault ramp latches, one edge later
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rail_en <= '0;
    else if (!enable || !vdd_ok || shut_now || (state == sfs_pkg::ST_LATCH) ||
             (state == sfs_pkg::ST_OFF))
      rail_en <= '0;
    else if ((state == sfs_pkg::ST_UP) && (peak_cnt == sfs_pkg::PK_LAST - 3'h1) &&
             peak_ev && any_out_fault)
      rail_en <= '0;
    else
    begin
      if (trough_ev && (peak_cnt == sfs_pkg::PK_SOFTSTART))
      begin
        rail_en.boost <= 1'b1;
        rail_en.logic_rail <= 1'b1;
      end
      if (peak_ev && (peak_cnt == sfs_pkg::PK_GATE_OFF - 3'h1))
        rail_en.gate_off <= 1'b1;
      if (trough_ev && (peak_cnt == sfs_pkg::PK_GATE_ON))
        rail_en.gate_on <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // protection and delayed-boost gates
  // ----------------------------------------------------------------
  // protection gate is high (transistor off) except from the second peak until a shutdown fault or the latch; an output-fault ramp keeps it low
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      input_protect_gate_out <= 1'b1;
    else if (!enable || !vdd_ok || shut_now || (state == sfs_pkg::ST_LATCH) ||
             (state == sfs_pkg::ST_OFF))
      input_protect_gate_out <= 1'b1;
    else if (peak_ev && (peak_cnt == sfs_pkg::PK_PROTECT - 3'h1))
      input_protect_gate_out <= 1'b0;
  end

  // open drain: only ever pulls low, released on any shutdown
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delayed_boost_gate_out <= 1'b0;
      delayed_boost_gate_oe <= 1'b0;
    end
    else if (!enable || !vdd_ok || shut_now || (state == sfs_pkg::ST_LATCH) ||
             (state == sfs_pkg::ST_OFF))
    begin
      delayed_boost_gate_out <= 1'b0;
      delayed_boost_gate_oe <= 1'b0;
    end
    else if (peak_ev && (peak_cnt == sfs_pkg::PK_DELAYED_BOOST_GATE_OUT - 3'h1))
      delayed_boost_gate_oe <= 1'b1;
  end

  // ----------------------------------------------------------------
  // soft-start and fault timers
  // ----------------------------------------------------------------
  sfs_timer #(
    .CYCLES(SS_CYCLES)
  ) u_ss_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(rail_en.boost),
    .expired(ss_done)
  );

  // digital backstop beside the 2.4 V comparator, whichever comes first
  sfs_timer #(
    .CYCLES(FAULT_CYCLES)
  ) u_fault_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(state == sfs_pkg::ST_FRAMP),
    .expired(fault_timeout)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      softstart_active <= 1'b0;
    else
      softstart_active <= rail_en.boost && !ss_done;
  end

  // ----------------------------------------------------------------
  // regulator modes and overvoltage drive cut
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      p_mode <= 1'b0;
    else
      p_mode <= integrator_cap_high;
  end

  // drive returns as soon as the output falls back, no latching here
  generate
    for (genvar i = 0; i < sfs_pkg::NUM_RAILS; i++)
    begin : g_ovp
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          drive_inhibit[i] <= 1'b0;
        else
          drive_inhibit[i] <= over_volt[i] && rail_bits[i];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_done <= 1'b0;
      latched_off <= 1'b0;
      powered_down <= 1'b1;
    end
    else
    begin
      seq_done <= (state == sfs_pkg::ST_RUN) || (state == sfs_pkg::ST_FRAMP);
      latched_off <= (state == sfs_pkg::ST_LATCH);
      powered_down <= (state == sfs_pkg::ST_OFF);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start_cond;
    (state == sfs_pkg::ST_OFF) && enable && vdd_ok;
  endsequence

  sequence s_first_charge;
    (state == sfs_pkg::ST_UP) ##1 (cap_drive.charge && cap_drive.fast);
  endsequence

  sequence s_out_fault_run;
    (state == sfs_pkg::ST_RUN) && enable && vdd_ok && !shut_now && any_out_fault;
  endsequence

  a_latch_holds: assert property (latched_off && enable && vdd_ok |=> latched_off)
    else $error("latch released without enable or supply cycle");
  a_disable_off: assert property (!enable |=> rail_en == '0 && input_protect_gate_out
    ##1 powered_down)
    else $error("device not powered down with enable low");
  a_ramp_start: assert property (s_start_cond |=> s_first_charge)
    else $error("cap ramp did not start fast");
  a_hold_wait: assert property (!enable |=> !cap_drive.charge || state == sfs_pkg::ST_OFF)
    else $error("cap ramp ran with enable low");
  a_six_peaks: assert property ($rose(seq_done) |-> peak_cnt == sfs_pkg::PK_LAST)
    else $error("sequence done without six peaks");
  a_protect_on: assert property ($fell(input_protect_gate_out) |-> peak_cnt == sfs_pkg::PK_PROTECT)
    else $error("protection gate low outside second peak");
  a_fault_gate: assert property (shut_now && enable && vdd_ok |=> input_protect_gate_out
    && !delayed_boost_gate_oe && state == sfs_pkg::ST_LATCH)
    else $error("fault did not release protection and latch");
  a_softstart: assert property ($rose(rail_en.boost) |-> peak_cnt == sfs_pkg::PK_SOFTSTART
    && rail_en.logic_rail ##1 softstart_active)
    else $error("soft-start not at third ramp");
  a_gate_off_en: assert property ($rose(rail_en.gate_off) |-> peak_cnt == sfs_pkg::PK_GATE_OFF)
    else $error("gate-off enabled off step");
  a_delayed_boost_gate_out_low: assert property ($rose(delayed_boost_gate_oe) |-> peak_cnt == sfs_pkg::PK_DELAYED_BOOST_GATE_OUT
    && !delayed_boost_gate_out)
    else $error("delayed-boost gate pulled off step");
  a_gate_on_en: assert property ($rose(rail_en.gate_on) |-> peak_cnt == sfs_pkg::PK_GATE_ON
    && state == sfs_pkg::ST_UP)
    else $error("gate-on enabled off step");
  a_run_hold: assert property ((state == sfs_pkg::ST_RUN) && enable && vdd_ok && !shut_now
    && !any_out_fault |=> ##1 cap_drive.hold)
    else $error("cap not held in run");
  a_immediate: assert property ((state == sfs_pkg::ST_RUN) && enable && vdd_ok && cap_fault
    |=> state == sfs_pkg::ST_LATCH ##1 latched_off)
    else $error("cap fault not immediate");
  a_fault_ramp: assert property (s_out_fault_run |=> state == sfs_pkg::ST_FRAMP
    ##1 cap_drive.fault_ramp)
    else $error("output fault did not start timed ramp");
  a_ramp_end: assert property ((state == sfs_pkg::ST_FRAMP) && enable && vdd_ok
    && cap_fault_thresh |=> state == sfs_pkg::ST_LATCH)
    else $error("threshold did not latch");
  a_recover: assert property ((state == sfs_pkg::ST_FRAMP) && enable && vdd_ok && !shut_now
    && !cap_fault_thresh && !fault_timeout && !any_out_fault |=> state == sfs_pkg::ST_RUN)
    else $error("cleared fault did not return to hold");
  a_pmode: assert property (integrator_cap_high [*2] |=> p_mode)
    else $error("proportional mode not taken");

endmodule : sfs_sequencer

// ==== sfs_timer.sv ====
`timescale 1ns/100ps

// counts run cycles, flags expiry, clears whenever run drops
module sfs_timer #(
  parameter int CYCLES = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic run,
  output logic expired
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // restart from zero each time, so a fault that clears and returns gets a fresh window
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      expired <= 1'b0;
    end
    else if (!run)
    begin
      cnt <= '0;
      expired <= 1'b0;
    end
    else if (cnt == LAST)
      expired <= 1'b1;
    else
      cnt <= cnt + 1'b1;
  end

endmodule : sfs_timer

// ==== tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
  logic mclk, rst_n, enable, vdd_ok, ref_bad, over_temp, cap_fault, icap_hi;
  logic slow, stuck_lo, stuck_hi, cap_upper, cap_lower, cap_mid, cap_fault_thresh;
  logic softstart_active, p_mode, input_protect_gate_out, delayed_boost_gate_out_out, delayed_boost_gate_out_oe;
  logic seq_done, latched_off, powered_down;
  logic [3:0] over_volt;
  logic [3:0] drive_inhibit;
  sfs_pkg::sfs_out_fault_s out_fault;
  sfs_pkg::sfs_cap_drive_s cap_drive;
  sfs_pkg::sfs_rail_en_s rail_en;
  int err_total;
  int checks_done;
  int peaks;

  // short counts keep the run brief
  sfs_sequencer #(.SS_CYCLES(20), .FAULT_CYCLES(400)) DUT (
    .mclk(mclk), .rst_n(rst_n), .enable(enable), .vdd_ok(vdd_ok),
    .cap_upper(cap_upper), .cap_lower(cap_lower), .cap_mid(cap_mid),
    .cap_fault_thresh(cap_fault_thresh), .cap_fault(cap_fault),
    .ref_bad(ref_bad), .over_temp(over_temp), .out_fault(out_fault),
    .over_volt(over_volt), .integrator_cap_high(icap_hi), .cap_drive(cap_drive),
    .rail_en(rail_en), .drive_inhibit(drive_inhibit),
    .softstart_active(softstart_active), .p_mode(p_mode),
    .input_protect_gate_out(input_protect_gate_out),
    .delayed_boost_gate_out(delayed_boost_gate_out_out), .delayed_boost_gate_oe(delayed_boost_gate_out_oe),
    .seq_done(seq_done), .latched_off(latched_off), .powered_down(powered_down));

  sfs_cap_model cap (
    .mclk(mclk), .rst_n(rst_n), .cap_drive(cap_drive), .slow(slow),
    .stuck_lo(stuck_lo), .stuck_hi(stuck_hi), .cap_upper(cap_upper),
    .cap_lower(cap_lower), .cap_mid(cap_mid), .cap_fault_thresh(cap_fault_thresh));

  // ------------------------------------------------------------
  // clock, peak counter, helpers
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // peaks seen while the block is charging the cap
  always @(posedge mclk)
    if (cap_upper && cap_drive.charge)
      peaks = peaks + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // bounded wait for a peak count, then let decoded outputs settle
  task automatic wpk(input int n);
    for (int i = 0; i < 4000 && peaks < n; i++)
      cyc(1);
    cyc(3);
  endtask : wpk

  task automatic restart();
    enable = 1'b0;
    cyc(4);
    peaks = 0;
    enable = 1'b1;
  endtask : restart

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_off();
    cyc(50);
    chk(8'(powered_down), 8'h01);
    chk(8'(cap_drive), 8'h00);
    chk(8'(input_protect_gate_out), 8'h01);
  endtask : t_off

  task automatic t_startup();
    restart();
    wpk(2);
    chk(8'(input_protect_gate_out), 8'h00);
    chk(8'(rail_en), 8'h00);
    for (int i = 0; i < 400 && rail_en.boost !== 1'b1; i++)
      cyc(1);
    chk(8'(rail_en), 8'h03);
    chk(8'(peaks), 8'h02);
    cyc(2);
    chk(8'(softstart_active), 8'h01);
    cyc(25);
    chk(8'(softstart_active), 8'h00);
    wpk(3);
    chk(8'(rail_en), 8'h03);
    wpk(4);
    chk(8'(rail_en), 8'h07);
    chk(8'(delayed_boost_gate_out_oe), 8'h00);
    wpk(5);
    chk(8'(delayed_boost_gate_out_oe), 8'h01);
    chk(8'(delayed_boost_gate_out_out), 8'h00);
    for (int i = 0; i < 400 && rail_en.gate_on !== 1'b1; i++)
      cyc(1);
    chk(8'(peaks), 8'h05);
    wpk(6);
    chk(8'(seq_done), 8'h01);
    chk(8'(cap_drive), 8'h02);
    cyc(300);
    chk(8'(peaks), 8'h06);
  endtask : t_startup

  // output fault: cleared in time, then held until the ramp latches
  task automatic t_framp();
    int n;
    out_fault.boost = 1'b1;
    cyc(30);
    chk(8'(cap_drive), 8'h11);
    out_fault = '0;
    cyc(3);
    chk(8'(cap_drive), 8'h02);
    chk(8'(latched_off), 8'h00);
    out_fault.protect_gate = 1'b1;
    for (n = 0; n < 600 && latched_off !== 1'b1; n++)
      cyc(1);
    chk(8'(n > 100), 8'h01);
    chk(8'(input_protect_gate_out), 8'h01);
    cyc(2);
    chk(8'(rail_en), 8'h00);
    out_fault = '0;
    cyc(20);
    chk(8'(latched_off), 8'h01);
  endtask : t_framp

  // reference, temperature and cap faults act without a ramp
  task automatic t_instant();
    for (int k = 0; k < 3; k++)
    begin
      restart();
      wpk(6);
      if (k == 0)
      begin
        over_volt = 4'hf;
        icap_hi = 1'b1;
        cyc(2);
        chk(8'(drive_inhibit), 8'h0f);
        chk(8'(p_mode), 8'h01);
        over_volt = 4'h0;
        icap_hi = 1'b0;
      end
      ref_bad = (k == 0);
      over_temp = (k == 1);
      cap_fault = (k == 2);
      cyc(3);
      chk(8'(latched_off), 8'h01);
      chk(8'(cap_drive.fault_ramp), 8'h00);
      ref_bad = 1'b0;
      over_temp = 1'b0;
      cap_fault = 1'b0;
    end
    vdd_ok = 1'b0;
    cyc(3);
    chk(8'(latched_off), 8'h00);
    chk(8'(powered_down), 8'h01);
    vdd_ok = 1'b1;
  endtask : t_instant

  task automatic t_early();
    slow = 1'b1;
    restart();
    wpk(1);
    over_temp = 1'b1;
    cyc(4);
    chk(8'(latched_off), 8'h01);
    chk(8'(rail_en), 8'h00);
    over_temp = 1'b0;
    slow = 1'b0;
  endtask : t_early

  task automatic t_stuck();
    stuck_lo = 1'b1;
    restart();
    cyc(400);
    chk(8'(peaks), 8'h00);
    stuck_lo = 1'b0;
    restart();
    wpk(1);
    stuck_hi = 1'b1;
    cyc(600);
    chk(8'(peaks), 8'h01);
    chk(8'(seq_done), 8'h00);
    stuck_hi = 1'b0;
  endtask : t_stuck

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    {enable, ref_bad, over_temp, cap_fault, icap_hi, slow, stuck_lo, stuck_hi} = '0;
    vdd_ok = 1'b1;
    over_volt = 4'h0;
    out_fault = '0;
    err_total = 0;
    checks_done = 0;
    peaks = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    t_off();
    t_startup();
    t_framp();
    t_instant();
    t_early();
    t_stuck();
    end_of_test();
  end

  // about five times the expected run length
  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb_top
